// File: haptic_supply_resonance_monitor_test.sv
`timescale 1ns/100ps
`include "hsrm_map.svh"
module haptic_supply_resonance_monitor_test;
	logic       clk = 1'b0, rst = 1'b1, driving = 1'b0, fixSel = 1'b0, autoCal = 1'b0;
	logic       emf = 1'b0, adcValid = 1'b0, regWrite, commutate, locked;
	logic [7:0] fixCode = 8'h00, adcCode = 8'h00, regAddr, regWdata, regRdata, v;
	int         err_count = 0, compares = 0;
	hsrm_host u_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
		.regRdata(regRdata));
	hsrm_monitor u_dut (.clk(clk), .rst(rst), .driving(driving), .fixedFrequencyDriveSelect(fixSel),
		.fixedPeriodCode(fixCode), .autoCalActive(autoCal), .backEmfZeroCross(emf),
		.supplyAdcCode(adcCode), .supplyAdcValid(adcValid), .regAddr(regAddr), .regWrite(regWrite),
		.regWdata(regWdata), .regRdata(regRdata), .commutate(commutate), .locked(locked));
	initial forever #4 clk = ~clk;
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic adc(input logic [7:0] c);
		@(posedge clk);
		adcCode <= c;
		adcValid <= 1'b1;
		@(posedge clk);
		adcValid <= 1'b0;
	endtask
	task automatic t_regs();
		u_host.rd(8'h22, v); check(v, 8'h00);
		u_host.wr(8'h30, 8'h55); u_host.rd(8'h30, v); check(v, 8'h00);
		u_host.wr(8'h22, 8'h5a); u_host.rd(8'h22, v); check(v, 8'h5a);
	endtask
	task automatic t_supply();
		adc(8'ha7); u_host.rd(8'h21, v); check(v, 8'h00);
		driving <= 1'b1; adc(8'hc4); u_host.rd(8'h21, v); check(v, 8'hc4);
		driving <= 1'b0; adc(8'h11); u_host.rd(8'h21, v); check(v, 8'hc4);
	endtask
	task automatic t_track();
		driving <= 1'b1; autoCal <= 1'b1; repeat (4) @(posedge clk);
		emf <= 1'b1; repeat (8) @(posedge clk); check(locked, 1'b1);
		repeat (13000) @(posedge clk); emf <= 1'b0; repeat (8) @(posedge clk);
		u_host.rd(8'h22, v); check(v, 8'h02);
		driving <= 1'b0; repeat (4) @(posedge clk); check(locked, 1'b0);
	endtask
	task automatic t_fixed();
		int n;
		fixSel <= 1'b1; fixCode <= 8'h01; driving <= 1'b1; repeat (5) @(posedge clk);
		u_host.rd(8'h22, v); check(v, 8'h01);
		// Wait for a drive pulse, then time the gap to the next one
		n = 0;
		while (commutate !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (commutate !== 1'b1 && n < 20000);
		check({7'h0, n == (`HSRM_UNIT_CYC / 2)}, 8'h01);
		driving <= 1'b0;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_supply();
		t_track();
		t_fixed();
		close_out();
	end
	initial begin
		#480000;
		err_count++;
		close_out();
	end
endmodule

// File: hsrm_host.sv
`timescale 1ns/100ps
module hsrm_host (
	input  wire logic       clk,
	output logic      [7:0] regAddr  = 8'h00,
	output logic            regWrite = 1'b0,
	output logic      [7:0] regWdata = 8'h00,
	input  wire logic [7:0] regRdata
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrite <= 1'b1;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		regWdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		@(posedge clk);
		d = regRdata;
	endtask
endmodule

// File: hsrm_map.svh
`ifndef HSRM_MAP_SVH
`define HSRM_MAP_SVH

// Register offsets (8-bit register address space)
`define HSRM_SUPPLY_OFS     8'h21
`define HSRM_PERIOD_OFS     8'h22
`define HSRM_SUPPLY_RST     8'h00
`define HSRM_PERIOD_RST     8'h00

// Clock rate and resonance-period code unit (ns per code, 98.46 us)
`define HSRM_CLK_MHZ        125
`define HSRM_PERIOD_UNIT_NS 98460
// Cycles per period code step, rounded down
`define HSRM_UNIT_CYC       ((`HSRM_PERIOD_UNIT_NS * `HSRM_CLK_MHZ) / 1000)

// Supply code full scale: volts = code * 5.6 / 255
`define HSRM_SUPPLY_FS_MV   5600
`define HSRM_SUPPLY_FS_CODE 255

`endif

// File: hsrm_monitor.sv
`timescale 1ns/100ps
`include "hsrm_map.svh"

module hsrm_monitor (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       driving,
	input  wire logic       fixedFrequencyDriveSelect,
	input  wire logic [7:0] fixedPeriodCode,
	input  wire logic       autoCalActive,
	input  wire logic       backEmfZeroCross,
	input  wire logic [7:0] supplyAdcCode,
	input  wire logic       supplyAdcValid,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	output logic            commutate,
	output logic            locked
);

	////////////////////////////////////////////////////////////////
	logic [7:0]       supplyCode_r, supplyCode_nxt;
	logic [7:0]       periodCode_r, periodCode_nxt;
	logic [2:0]       emfSync_r;
	logic             emfLevel_r, emfLevel_nxt;
	logic [23:0]      cycCnt_r, cycCnt_nxt;
	logic [23:0]      halfCyc_r, halfCyc_nxt;
	logic [23:0]      driveCnt_r, driveCnt_nxt;
	logic             commutate_r, commutate_nxt;
	hsrm_pkg::hsrm_trk_t state_r, state_nxt;
	logic             emfEdge;

	localparam logic [23:0] UnitCyc = 24'(`HSRM_UNIT_CYC);

	// Period in cycles to 8-bit code of 98.46 us steps, saturating
	function automatic logic [7:0] cyc_to_code(input logic [23:0] cyc);
		logic [23:0] q;
		q = cyc / UnitCyc;
		cyc_to_code = (q > 24'h0000ff) ? 8'hff : q[7:0];
	endfunction

	////////////////////////////////////////////////////////////////
	// Back-EMF zero crossing: three stages, change when stages 2 and 3 agree
	always_ff @(posedge clk) begin
		if (rst)
			emfSync_r <= 3'h0;
		else
			emfSync_r <= {emfSync_r[1:0], backEmfZeroCross};
	end

	always_comb begin
		emfLevel_nxt = emfLevel_r;
		if (emfSync_r[2] == emfSync_r[1])
			emfLevel_nxt = emfSync_r[2];
	end

	// Each half-cycle of back-EMF shows as a level change
	assign emfEdge = (emfLevel_nxt != emfLevel_r);

	////////////////////////////////////////////////////////////////
	// Tracker; autoCalActive is deliberately not an input to it
	always_comb begin
		state_nxt     = state_r;
		cycCnt_nxt    = cycCnt_r;
		halfCyc_nxt   = halfCyc_r;
		driveCnt_nxt  = driveCnt_r;
		commutate_nxt = 1'b0;
		periodCode_nxt = periodCode_r;
		if (!driving) begin
			state_nxt  = hsrm_pkg::TrkIdle;
			cycCnt_nxt = 24'h0;
		end else if (fixedFrequencyDriveSelect) begin
			// Programmed period, no back-EMF tracking
			state_nxt = hsrm_pkg::TrkIdle;
			halfCyc_nxt = ({16'h0, fixedPeriodCode} * UnitCyc) >> 1;
			if (driveCnt_r + 24'h1 >= halfCyc_nxt) begin
				driveCnt_nxt  = 24'h0;
				commutate_nxt = 1'b1;
			end else
				driveCnt_nxt = driveCnt_r + 24'h1;
		end else begin
			cycCnt_nxt = (cycCnt_r == 24'hffffff) ? cycCnt_r : cycCnt_r + 24'h1;
			driveCnt_nxt = driveCnt_r + 24'h1;
			case (state_r)
				hsrm_pkg::TrkIdle: begin
					state_nxt  = hsrm_pkg::TrkWaitLock;
					cycCnt_nxt = 24'h0;
				end
				hsrm_pkg::TrkWaitLock: begin
					// First back-EMF edge gives the lock; cycles since entering wait are taken as the half cycle
					if (emfEdge) begin
						halfCyc_nxt   = cycCnt_r;
						cycCnt_nxt    = 24'h0;
						driveCnt_nxt  = 24'h0;
						commutate_nxt = 1'b1;
						state_nxt     = hsrm_pkg::TrkTrack;
					end
				end
				hsrm_pkg::TrkTrack: begin
					if (emfEdge) begin
						// Re-measure every half cycle and resync drive
						halfCyc_nxt    = cycCnt_r;
						periodCode_nxt = cyc_to_code({cycCnt_r[22:0], 1'b0});
						cycCnt_nxt     = 24'h0;
						driveCnt_nxt   = 24'h0;
						commutate_nxt  = 1'b1;
					end else if (driveCnt_r + 24'h1 >= halfCyc_r) begin
						driveCnt_nxt  = 24'h0;
						commutate_nxt = 1'b1;
					end
				end
				default: state_nxt = hsrm_pkg::TrkIdle;
			endcase
		end
		if (fixedFrequencyDriveSelect && driving)
			periodCode_nxt = fixedPeriodCode;
		if (regWrite && regAddr == `HSRM_PERIOD_OFS)
			periodCode_nxt = regWdata;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r      <= hsrm_pkg::TrkIdle;
			emfLevel_r   <= 1'b0;
			cycCnt_r     <= 24'h0;
			halfCyc_r    <= 24'h0;
			driveCnt_r   <= 24'h0;
			commutate_r  <= 1'b0;
			periodCode_r <= `HSRM_PERIOD_RST;
		end else begin
			state_r      <= state_nxt;
			emfLevel_r   <= emfLevel_nxt;
			cycCnt_r     <= cycCnt_nxt;
			halfCyc_r    <= halfCyc_nxt;
			driveCnt_r   <= driveCnt_nxt;
			commutate_r  <= commutate_nxt;
			periodCode_r <= periodCode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Supply code: live while driving, held when idle except for host writes to the supply offset
	always_comb begin
		supplyCode_nxt = supplyCode_r;
		if (driving && supplyAdcValid)
			supplyCode_nxt = supplyAdcCode;
		else if (regWrite && regAddr == `HSRM_SUPPLY_OFS)
			supplyCode_nxt = regWdata;
	end

	always_ff @(posedge clk) begin
		if (rst)
			supplyCode_r <= `HSRM_SUPPLY_RST;
		else
			supplyCode_r <= supplyCode_nxt;
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		case (regAddr)
			`HSRM_SUPPLY_OFS: regRdata = supplyCode_r;
			`HSRM_PERIOD_OFS: regRdata = periodCode_r;
			default:          regRdata = 8'h00;
		endcase
	end

	assign commutate = commutate_r;
	assign locked    = (state_r == hsrm_pkg::TrkTrack);

endmodule

// File: hsrm_pkg.sv
package hsrm_pkg;
	typedef enum logic [1:0] {
		TrkIdle,
		TrkWaitLock,
		TrkTrack
	} hsrm_trk_t;
endpackage

// File: hsrm_properties.sv
`timescale 1ns/100ps
module hsrm_properties (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       driving,
	input wire logic       fixedFrequencyDriveSelect,
	input wire logic [7:0] fixedPeriodCode,
	input wire logic       backEmfZeroCross,
	input wire logic [7:0] supplyAdcCode,
	input wire logic       supplyAdcValid,
	input wire logic [7:0] regAddr,
	input wire logic       regWrite,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic       commutate,
	input wire logic       locked
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence rdSupply; regAddr == 8'h21; endsequence
	supply_capture_a: assert property (driving && supplyAdcValid ##1 rdSupply
		|-> regRdata == $past(supplyAdcCode)) else $error("supply not captured");
	idle_hold_a: assert property (!driving && !regWrite ##1 $stable(regAddr) &&
		regAddr inside {8'h21, 8'h22} |-> $stable(regRdata)) else $error("idle change");
	period_write_a: assert property (regWrite && regAddr == 8'h22 ##1 regAddr == 8'h22
		|-> regRdata == $past(regWdata)) else $error("period write lost");
	lock_time_a: assert property (driving && $past(driving) && !fixedFrequencyDriveSelect
		&& !locked && $changed(backEmfZeroCross) |-> ##[1:8] locked) else $error("no lock");
	lock_commutate_a: assert property ($rose(locked) |-> ##[0:1] commutate)
		else $error("no commutate at lock");
	commutate_pulse_a: assert property (commutate |=> !commutate)
		else $error("commutate too long");
	locked_idle_a: assert property (!driving [*3] |-> !locked) else $error("locked idle");
	period_fixed_a: assert property ((fixedFrequencyDriveSelect && driving && !regWrite
		&& $stable(fixedPeriodCode)) [*3] ##0 regAddr == 8'h22
		|-> regRdata == fixedPeriodCode) else $error("fixed period wrong");
endmodule
bind hsrm_monitor hsrm_properties u_props (.*);
